// ===== bridge_pkg.sv
package bridge_pkg;

    // Reset values of the bridge state.
    localparam logic RST_PENDING = 1'b0;
    localparam logic RST_ARMED = 1'b0;
    localparam logic RST_DRIVE = 1'b0;

    // Synchronised copies of the pins coming from both buses.
    typedef struct packed {
        logic mod_trig;
        logic inst_trig;
        logic enable_gate;
        logic low_start;
        logic ready;
    } pins_t;

    // Whole state of the bridge.
    typedef struct packed {
        pins_t sync1;
        pins_t sync2;
        logic mod_trig_prev;
        logic inst_trig_prev;
        logic pending;
        logic armed;
        logic inst_trig_drive;
        logic mod_trig_drive;
        logic ready_hold;
    } state_t;

endpackage

// ===== trigger_start_bus_bridge.sv
`timescale 1ns/100ps
module trigger_start_bus_bridge (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic mod_trig_i,
    input wire logic master_enable_gate_i,
    input wire logic low_start_line_n_i,
    input wire logic inst_trig_i,
    input wire logic ready_i,
    input wire logic start_req_i,
    input wire logic start_cmd_i,
    output logic mod_trig_o,
    output logic mod_trig_oe_o,
    output logic inst_trig_o,
    output logic inst_trig_oe_o,
    output logic ready_o,
    output logic ready_oe_o,
    output logic armed_o
);

    bridge_pkg::state_t st;
    bridge_pkg::state_t next_st;
    logic mod_edge;
    logic inst_edge;
    logic start_seen;

    // Edge detection on second-stage synchroniser outputs only.
    // The first stage may still be metastable, so nothing but the second stage reads it.
    assign mod_edge = st.sync2.mod_trig & ~st.mod_trig_prev;
    assign inst_edge = st.sync2.inst_trig & ~st.inst_trig_prev;
    assign start_seen = start_cmd_i | ~st.sync2.low_start;

    // Next-state logic for trigger repeating and the ready hold.
    always_comb begin
        next_st = st;
        next_st.sync1.mod_trig = mod_trig_i;
        next_st.sync1.inst_trig = inst_trig_i;
        next_st.sync1.enable_gate = master_enable_gate_i;
        next_st.sync1.low_start = low_start_line_n_i;
        next_st.sync1.ready = ready_i;
        next_st.sync2 = st.sync1;
        next_st.mod_trig_prev = st.sync2.mod_trig;
        next_st.inst_trig_prev = st.sync2.inst_trig;
        // Module-side trigger level repeats straight through, no gate.
        next_st.inst_trig_drive = st.sync2.mod_trig;
        // Instrument-side trigger: pass if gate open, else hold pending.
        if (inst_edge || st.pending) begin
            if (st.sync2.enable_gate) begin
                next_st.mod_trig_drive = 1'b1;
                next_st.pending = 1'b0;
            end else begin
                next_st.mod_trig_drive = 1'b0;
                next_st.pending = 1'b1;
            end
        end else begin
            next_st.mod_trig_drive = 1'b0;
        end
        // Arm on request; release on start command or low start line.
        // Release is tested first so that a start in the same cycle as a request wins.
        if (start_seen) begin
            next_st.armed = 1'b0;
        end else if (start_req_i) begin
            next_st.armed = 1'b1;
        end
        // Hold the line only once it is seen low while armed.
        // Our own hold keeps the wire low, so the hold latches itself until release.
        next_st.ready_hold = next_st.armed & (st.ready_hold | ~st.sync2.ready);
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            st <= '0;
            st.sync1.low_start <= 1'b1;
            st.sync2.low_start <= 1'b1;
            st.sync1.ready <= 1'b1;
            st.sync2.ready <= 1'b1;
            st.pending <= bridge_pkg::RST_PENDING;
            st.armed <= bridge_pkg::RST_ARMED;
            st.mod_trig_drive <= bridge_pkg::RST_DRIVE;
            st.inst_trig_drive <= bridge_pkg::RST_DRIVE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from state flip-flops except ready_o, which is tied low; triggers drive high only while asserted, ready is open-drain style.
    assign mod_trig_o = st.mod_trig_drive;
    assign mod_trig_oe_o = st.mod_trig_drive;
    assign inst_trig_o = st.inst_trig_drive;
    assign inst_trig_oe_o = st.inst_trig_drive;
    assign ready_o = 1'b0;
    assign ready_oe_o = st.ready_hold;
    assign armed_o = st.armed;

    // A synced module-side trigger level shows on the instrument side one edge later.
    a_trig_forward: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        st.sync2.mod_trig |=> inst_trig_o)
        else $error("module trigger not repeated");

    // A module-side rising edge gives a rising instrument-side trigger next edge.
    a_fwd_rise: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mod_edge |=> $rose(inst_trig_o))
        else $error("module trigger edge not repeated");

    // A low module-side level is never repeated as a trigger.
    a_fwd_fall: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !st.sync2.mod_trig |=> !inst_trig_o)
        else $error("instrument trigger without source");

    // The instrument-side enable tracks the driven level of that trigger.
    a_inst_enable: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        inst_trig_oe_o == inst_trig_o)
        else $error("instrument trigger enable mismatch");

    // A fresh trigger with the gate closed is held and not driven.
    a_gate_block: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (inst_edge && !st.sync2.enable_gate) |=> (st.pending && !mod_trig_o))
        else $error("trigger passed with gate closed");

    // A closed gate never lets a module-side trigger out.
    a_gate_closed: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !st.sync2.enable_gate |=> !mod_trig_o)
        else $error("module trigger driven with gate closed");

    // A held trigger stays held while the gate remains closed.
    a_pend_keep: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st.pending && !st.sync2.enable_gate) |=> st.pending)
        else $error("held trigger dropped");

    // With the gate open a fresh trigger passes on the next edge.
    a_gate_pass: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (inst_edge && st.sync2.enable_gate) |=> mod_trig_o)
        else $error("trigger not passed with gate open");

    // A start request outside a release cycle arms the bridge.
    a_arm_req: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (start_req_i && !start_seen) |=> armed_o)
        else $error("start request did not arm");

    // Once armed the bridge stays armed until a start is seen.
    a_arm_keep: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (armed_o && !start_seen) |=> armed_o)
        else $error("arm lost without start");

    // Without a request an idle bridge does not arm itself.
    a_arm_idle: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (!armed_o && !start_req_i) |=> !armed_o)
        else $error("bridge armed without request");

    // The hold engages only after the line was seen low.
    a_no_pull: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(ready_oe_o) |-> $past(st.sync2.ready) == 1'b0)
        else $error("ready pulled low while high");

    // A high line with no hold in place is never taken low.
    a_hold_needs_low: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (!ready_oe_o && st.sync2.ready) |=> !ready_oe_o)
        else $error("hold engaged on a high line");

    // Holding is only ever done while armed.
    a_hold_armed: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        ready_oe_o |-> armed_o)
        else $error("ready held while not armed");

    // An engaged hold stays until a start is seen.
    a_hold_keep: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (ready_oe_o && !start_seen) |=> ready_oe_o)
        else $error("ready hold lost without start");

    // The ready driver only ever holds low.
    a_ready_level: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        ready_o == 1'b0)
        else $error("ready driven high");

    // A start command or low start line drops arm and hold on the next edge.
    a_start_release: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        start_seen |=> !armed_o && !ready_oe_o)
        else $error("hold not released on start");

    // Every module-side pulse comes from a fresh or held instrument trigger.
    a_no_origin: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(mod_trig_o) |-> $past(inst_edge || st.pending))
        else $error("bridge originated a trigger");

    // With no trigger to deliver the module side stays quiet.
    a_no_spur: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (!inst_edge && !st.pending) |=> !mod_trig_o)
        else $error("module trigger without source");

    // The module-side enable tracks the driven level of that trigger.
    a_mod_enable: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mod_trig_oe_o == mod_trig_o)
        else $error("module trigger enable mismatch");

    // A held trigger is delivered and cleared as soon as the gate opens.
    a_pending_clr: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (st.pending && st.sync2.enable_gate) |=> (!st.pending && mod_trig_o))
        else $error("pending trigger not delivered");

endmodule // trigger_start_bus_bridge

// ===== far_side_model.sv
`timescale 1ns/100ps
// Far-side peers: the gate owner and instrument peers on a pulled-up ready line.
module far_side_model (
    input wire logic window_i,
    input wire logic hold_i,
    input wire logic ready_drv_i,
    input wire logic ready_en_i,
    output logic gate_o,
    output logic ready_wire_o,
    output logic run_o
);
    // The gate is open only inside the window; peers run only on a high ready line.
    assign gate_o = window_i;
    assign ready_wire_o = !(hold_i || (ready_en_i && !ready_drv_i));
    assign run_o = ready_wire_o;
endmodule // far_side_model

// ===== test_trigger_start_bus_bridge.sv
`timescale 1ns/100ps
module test_trigger_start_bus_bridge;
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, mtr = 1'b0, win = 1'b0, sn = 1'b1, itr = 1'b0;
    logic hold = 1'b0, req = 1'b0, cmd = 1'b0, gate, rw, run, mt, mte, it, ite, rd, rde, arm;
    int seed = 9, bad_count = 0, check_count = 0, cycles = 0, n;
    always #4 clk_sys_i = ~clk_sys_i;
    far_side_model i_far (.window_i(win), .hold_i(hold), .ready_drv_i(rd), .ready_en_i(rde),
        .gate_o(gate), .ready_wire_o(rw), .run_o(run));
    trigger_start_bus_bridge i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .mod_trig_i(mtr), .master_enable_gate_i(gate), .low_start_line_n_i(sn),
        .inst_trig_i(itr), .ready_i(rw), .start_req_i(req), .start_cmd_i(cmd),
        .mod_trig_o(mt), .mod_trig_oe_o(mte), .inst_trig_o(it), .inst_trig_oe_o(ite),
        .ready_o(rd), .ready_oe_o(rde), .armed_o(arm));
    // Counts one comparison and reports a mismatch.
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // Waits at most lim falling edges for an output to go high.
    task automatic wait_hi(ref logic s, input int lim, output int k);
        k = 0;
        while (s !== 1'b1 && k < lim) begin
            @(negedge clk_sys_i);
            k++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    // Triggers both ways with a random gate, then armed starts.
    initial begin
        repeat (16) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        for (int i = 0; i < 8; i++) begin
            win = 1'($random(seed));
            mtr = 1'b1;
            wait_hi(it, 6, n);
            check(n <= 4 && ite === 1'b1, "module trigger late");
            check(mt === 1'b0, "trigger echoed");
            mtr = 1'b0;
            repeat (6) @(negedge clk_sys_i);
            itr = 1'b1;
            @(negedge clk_sys_i);
            itr = 1'b0;
            wait_hi(mt, win ? 6 : 10, n);
            check(win ? n <= 4 : n == 10, "gated trigger wrong");
            win = 1'b1;
            wait_hi(mt, 6, n);
            check(n <= 4 && mte === 1'b1, "instrument trigger lost");
            repeat (3) @(negedge clk_sys_i);
            check(mt === 1'b0, "pending not cleared");
        end
        for (int i = 0; i < 2; i++) begin
            req = 1'b1;
            @(negedge clk_sys_i);
            req = 1'b0;
            repeat (6) @(negedge clk_sys_i);
            check(arm === 1'b1 && rde === 1'b0 && rw === 1'b1, "ready pulled");
            hold = 1'b1;
            repeat (5) @(negedge clk_sys_i);
            hold = 1'b0;
            repeat (2) @(negedge clk_sys_i);
            check(rw === 1'b0 && run === 1'b0, "ready not held");
            check(rde === 1'b1 && rd === 1'b0, "hold not driven low");
            cmd = (i == 0);
            sn = (i == 0);
            repeat (4) @(negedge clk_sys_i);
            check(arm === 1'b0 && rw === 1'b1, "hold not released");
            cmd = 1'b0;
            sn = 1'b1;
            repeat (4) @(negedge clk_sys_i);
        end
        end_of_test();
    end
endmodule // test_trigger_start_bus_bridge
